// ---- include/aph_pkg.sv ----
// Package with register map, field layout and timing for the perf hint bank
package aph_pkg;
  // Register byte offsets (64-bit registers as low/high word pairs)
  localparam logic [11:0] OFF_THR_LO   = 12'h000;
  localparam logic [11:0] OFF_THR_HI   = 12'h004;
  localparam logic [11:0] OFF_PKG_LO   = 12'h008;
  localparam logic [11:0] OFF_PKG_HI   = 12'h00C;
  localparam logic [11:0] OFF_FLAGS    = 12'h010;
  localparam logic [11:0] OFF_THERM    = 12'h014;
  localparam logic [11:0] OFF_PRODUCTIVE_CYCLE_COUNT_LO  = 12'h018;
  localparam logic [11:0] OFF_PRODUCTIVE_CYCLE_COUNT_HI  = 12'h01C;
  // Field positions
  localparam int MIN_LSB   = 0;
  localparam int MAX_LSB   = 8;
  localparam int TGT_LSB   = 16;
  localparam int BIAS_LSB  = 24;
  localparam int WIN_LSB   = 0;
  localparam int WIN_EXP   = 7;
  localparam int FOLLOW_B  = 10;
  localparam int HI_USED   = 11;
  localparam int CHG_B     = 0;
  localparam int MISS_B    = 2;
  localparam int CUR_ST_B  = 12;
  localparam int CUR_LOG_B = 13;
  localparam int XD_ST_B   = 14;
  localparam int XD_LOG_B  = 15;
  // Reset values
  localparam logic [7:0] BIAS_RST  = 8'h80;
  localparam logic [7:0] TGT_RST   = 8'h00;
  localparam logic [9:0] WIN_RST   = 10'h000;
  // Reporting holdoff: one second
  localparam int unsigned CLK_HZ      = 40000000;
  localparam int unsigned HOLDOFF_S   = 1;
  localparam int unsigned HOLDOFF_CYC = CLK_HZ * HOLDOFF_S;
  // Shortest excursion that counts as sustained
  localparam int unsigned SUSTAIN_US  = 4000;
  localparam int unsigned SUSTAIN_CYC = SUSTAIN_US * (CLK_HZ / 1000000);
endpackage : aph_pkg

// ---- logic/aph_regs.sv ----
// Perf hint register bank with APB slave, status flags and productive counter
`timescale 1ns/1ps
`default_nettype none
module aph_regs #(
  parameter int unsigned HOLDOFF_CYC = aph_pkg::HOLDOFF_CYC,
  parameter int unsigned SUSTAIN_CYC = aph_pkg::SUSTAIN_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        auto_enabled,      // Autonomous control enabled
  input  wire logic [31:0] capability_register,
  input  wire logic        cap_window,        // Window field supported
  input  wire logic        cap_bias,          // Bias field supported
  input  wire logic        cap_package,       // Package register supported
  input  wire logic [1:0]  notify_enable_register,
  input  wire logic [7:0]  legacy_energy_bias_register,
  input  wire logic        level_changed,     // Sustained level moved
  input  wire logic        below_floor,       // Running under min hint
  input  wire logic        current_limit,     // Current limit exceeded
  input  wire logic        cross_limit,       // Other domain limiting
  input  wire logic        actual_cycle_tick, // Actual-cycle increment
  input  wire logic        productive,        // Cycle judged productive
  output logic      [7:0]  eff_min,
  output logic      [7:0]  eff_max,
  output logic      [7:0]  eff_target,
  output logic      [7:0]  eff_bias,
  output logic             eff_autonomous,    // Autonomous target pick
  output logic             eff_fixed,         // Optimizations disabled
  output logic             window_valid,      // Explicit window in force
  output logic      [6:0]  window_mant,
  output logic      [2:0]  window_exp,
  output logic             notify              // One-cycle notification
);
  localparam int CW = $clog2(HOLDOFF_CYC + 1);
  localparam int SW = $clog2(SUSTAIN_CYC + 1);

  // Register storage
  logic [31:0] thr_lo_q;      // Thread hints low word
  logic [10:0] thr_hi_q;      // Window and follow bit
  logic [31:0] pkg_lo_q;      // Package hints low word
  logic [9:0]  pkg_hi_q;      // Package window
  logic        chg_q;         // Level change flag
  logic        miss_q;        // Floor missed flag
  logic        cur_log_q;     // Current limit log
  logic        xd_log_q;      // Cross-domain log
  logic [63:0] productive_cycle_count_q;        // productive_cycle_count
  logic [CW-1:0] hold_q;      // Holdoff timer after a report
  logic [SW-1:0] sus_q;       // Floor miss duration
  logic [1:0]  cl_sync_q;     // Current limit synchroniser
  logic [1:0]  xd_sync_q;     // Cross limit synchroniser
  logic        cur_st;        // Synchronised current limit
  logic        xd_st;         // Synchronised cross limit

  // APB decode
  wire        access  = psel && penable;
  wire        wr      = access && pwrite;
  wire        gated   = (paddr <= aph_pkg::OFF_THERM) && !auto_enabled;
  wire        hit_tl  = paddr == aph_pkg::OFF_THR_LO;
  wire        hit_th  = paddr == aph_pkg::OFF_THR_HI;
  wire        hit_pl  = (paddr == aph_pkg::OFF_PKG_LO) && cap_package;
  wire        hit_ph  = (paddr == aph_pkg::OFF_PKG_HI) && cap_package;
  wire        hit_fl  = paddr == aph_pkg::OFF_FLAGS;
  wire        hit_th2 = paddr == aph_pkg::OFF_THERM;
  wire        hit_cl  = paddr == aph_pkg::OFF_PRODUCTIVE_CYCLE_COUNT_LO;
  wire        hit_ch  = paddr == aph_pkg::OFF_PRODUCTIVE_CYCLE_COUNT_HI;
  wire        mapped  = hit_tl | hit_th | hit_pl | hit_ph | hit_fl |
                        hit_th2 | hit_cl | hit_ch;
  wire        bad     = !mapped || gated;
  wire        wr_ok   = wr && !bad;
  wire [31:0] wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}},
                         {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [7:0]  floor_v = capability_register[31:24];
  wire [7:0]  ceil_v  = capability_register[7:0];

  // Supported-field masks; unsupported ones read zero and drop writes
  wire [31:0] lo_sup  = {{8{cap_bias}}, 24'hFFFFFF};
  wire [10:0] hi_sup  = {1'b1, {10{cap_window}}};
  wire [31:0] thr_lo_w = (thr_lo_q & ~wmask) | (pwdata & wmask);
  wire [31:0] pkg_lo_w = (pkg_lo_q & ~wmask) | (pwdata & wmask);
  wire [10:0] hi_w     = pstrb[1:0] == 2'b11 ? pwdata[10:0] :
                         {pstrb[1] ? pwdata[10:8] : thr_hi_q[10:8],
                          pstrb[0] ? pwdata[7:0] : thr_hi_q[7:0]};
  wire [9:0]  phi_w    = {pstrb[1] ? pwdata[9:8] : pkg_hi_q[9:8],
                          pstrb[0] ? pwdata[7:0] : pkg_hi_q[7:0]};
  // Unsupported bits keep their old value, so a write cannot touch them
  wire [31:0] thr_lo_n = (thr_lo_w & lo_sup) | (thr_lo_q & ~lo_sup);
  wire [31:0] pkg_lo_n = (pkg_lo_w & lo_sup) | (pkg_lo_q & ~lo_sup);
  wire [10:0] thr_hi_n = (hi_w & hi_sup) | (thr_hi_q & ~hi_sup);
  wire [9:0]  pkg_hi_n = (phi_w & hi_sup[9:0]) | (pkg_hi_q & ~hi_sup[9:0]);

  // Hint registers; reserved bits 63:43 are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_lo_q <= 32'h00000000;
      thr_hi_q <= 11'h000;
      pkg_lo_q <= 32'h00000000;
      pkg_hi_q <= 10'h000;
    end else if (!auto_enabled) begin
      // Load capability defaults until control is enabled
      thr_lo_q <= {aph_pkg::BIAS_RST, aph_pkg::TGT_RST, ceil_v, floor_v}
                  & lo_sup;
      pkg_lo_q <= {aph_pkg::BIAS_RST, aph_pkg::TGT_RST, ceil_v, floor_v}
                  & lo_sup;
      thr_hi_q <= {1'b0, aph_pkg::WIN_RST};
      pkg_hi_q <= aph_pkg::WIN_RST;
    end else begin
      // Stored as written, clipped only on use
      if (wr_ok && hit_tl) thr_lo_q <= thr_lo_n;
      if (wr_ok && hit_th) thr_hi_q <= thr_hi_n;
      if (wr_ok && hit_pl) pkg_lo_q <= pkg_lo_n;
      if (wr_ok && hit_ph) pkg_hi_q <= pkg_hi_n;
    end
  end

  // Effective source: package when follow bit set and package supported
  wire        follow = thr_hi_q[aph_pkg::FOLLOW_B] && cap_package;
  wire [31:0] src_lo = follow ? pkg_lo_q : thr_lo_q;
  wire [9:0]  src_hi = follow ? pkg_hi_q : thr_hi_q[9:0];
  wire [7:0]  raw_min = src_lo[aph_pkg::MIN_LSB +: 8];
  wire [7:0]  raw_max = src_lo[aph_pkg::MAX_LSB +: 8];
  wire [7:0]  raw_tgt = src_lo[aph_pkg::TGT_LSB +: 8];

  // Clip to floor..ceiling
  function automatic logic [7:0] clip(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
    clip = v < lo ? lo : (v > hi ? hi : v);
  endfunction
  wire [7:0] c_min = clip(raw_min, floor_v, ceil_v);
  wire [7:0] c_max_r = clip(raw_max, floor_v, ceil_v);
  wire [7:0] c_max = c_max_r < c_min ? c_min : c_max_r;

  // Effective outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_min        <= 8'h00;
      eff_max        <= 8'h00;
      eff_target     <= 8'h00;
      eff_bias       <= 8'h00;
      eff_autonomous <= 1'b1;
      eff_fixed      <= 1'b0;
      window_valid   <= 1'b0;
      window_mant    <= 7'h00;
      window_exp     <= 3'h0;
    end else begin
      eff_min    <= c_min;
      eff_max    <= c_max;
      // Zero target keeps autonomous pick
      eff_target <= raw_tgt == 8'h00 ? 8'h00 : clip(raw_tgt, c_min, c_max);
      eff_autonomous <= raw_tgt == 8'h00;
      // Bias from legacy register when unsupported
      eff_bias   <= cap_bias ? src_lo[aph_pkg::BIAS_LSB +: 8]
                             : legacy_energy_bias_register;
      eff_fixed  <= c_min == c_max;
      // Window only with zero target and nonzero value
      window_valid <= cap_window && raw_tgt == 8'h00 && src_hi != 10'h000;
      // Mantissa x 10^exp microseconds
      window_mant <= src_hi[aph_pkg::WIN_LSB +: 7];
      window_exp  <= src_hi[aph_pkg::WIN_EXP +: 3];
    end
  end

  // Limit input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_sync_q <= 2'b00;
      xd_sync_q <= 2'b00;
    end else begin
      cl_sync_q <= {cl_sync_q[0], current_limit};
      xd_sync_q <= {xd_sync_q[0], cross_limit};
    end
  end
  assign cur_st = cl_sync_q[1];
  assign xd_st  = xd_sync_q[1];

  // Floor miss must last SUSTAIN_CYC before it counts
  wire sustained = sus_q == SW'(SUSTAIN_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sus_q <= '0;
    else if (!below_floor) sus_q <= '0;
    else if (!sustained) sus_q <= sus_q + SW'(1);
  end

  // Reporting events with one-second holdoff
  wire idle    = hold_q == '0;
  wire set_chg = level_changed && idle && !chg_q && auto_enabled;
  wire set_miss = sustained && idle && !miss_q && auto_enabled;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_q <= '0;
    else if (set_chg || set_miss) hold_q <= CW'(HOLDOFF_CYC);
    else if (!idle) hold_q <= hold_q - CW'(1);
  end

  // Sticky flags; a set wins over a clear written in the same cycle
  wire wr_fl = wr_ok && hit_fl && pstrb[0];
  wire wr_tm = wr_ok && hit_th2 && pstrb[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_q     <= 1'b0;
      miss_q    <= 1'b0;
      cur_log_q <= 1'b0;
      xd_log_q  <= 1'b0;
    end else begin
      if (set_chg) chg_q <= 1'b1;
      else if (wr_fl && !pwdata[aph_pkg::CHG_B]) chg_q <= 1'b0;
      if (set_miss) miss_q <= 1'b1;
      else if (wr_fl && !pwdata[aph_pkg::MISS_B]) miss_q <= 1'b0;
      if (cur_st) cur_log_q <= 1'b1;
      else if (wr_tm && !pwdata[aph_pkg::CUR_LOG_B]) cur_log_q <= 1'b0;
      if (xd_st) xd_log_q <= 1'b1;
      else if (wr_tm && !pwdata[aph_pkg::XD_LOG_B]) xd_log_q <= 1'b0;
    end
  end

  // Notify only on a fresh setting, when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) notify <= 1'b0;
    else notify <= (set_chg && notify_enable_register[0]) ||
                   (set_miss && notify_enable_register[1]);
  end

  // Productive counter, free of the enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) productive_cycle_count_q <= 64'h0000000000000000;
    else if (actual_cycle_tick && productive) productive_cycle_count_q <= productive_cycle_count_q + 64'h1;
  end

  // Read mux
  wire [31:0] flags_r = {29'h0, miss_q, 1'b0, chg_q};
  wire [31:0] therm_r = {16'h0, xd_log_q, xd_st, cur_log_q, cur_st, 12'h000};
  // Unsupported fields read zero; stored bits return if support does
  wire [31:0] rmux =
      hit_tl  ? thr_lo_q & lo_sup :
      hit_th  ? {21'h0, thr_hi_q & hi_sup} :
      hit_pl  ? pkg_lo_q & lo_sup :
      hit_ph  ? {22'h0, pkg_hi_q & hi_sup[9:0]} :
      hit_fl  ? flags_r :
      hit_th2 ? therm_r :
      hit_cl  ? productive_cycle_count_q[31:0] :
      hit_ch  ? productive_cycle_count_q[63:32] : 32'h00000000;

  // Zero-wait slave; read data registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) prdata <= bad ? 32'h0 : rmux;
  end
  assign pready  = 1'b1;
  assign pslverr = access && bad;

  // Guards; presetn in an antecedent skips the edge that leaves reset
  chk_bias_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn && !auto_enabled && cap_bias |=> thr_lo_q[31:24] == 8'h80)
    else $error("bias default wrong");
  chk_follow_pkg: assert property (
    @(posedge pclk) disable iff (!presetn)
    follow && cap_bias |=> eff_bias == $past(pkg_lo_q[31:24]))
    else $error("package follow ignored");
  chk_legacy_bias: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cap_bias |=> eff_bias == $past(legacy_energy_bias_register))
    else $error("legacy bias unused");
  chk_window_tgt: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_tgt != 8'h00 |=> !window_valid)
    else $error("window active with target");
  chk_min_clip: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn && floor_v <= ceil_v |=> eff_min >= $past(floor_v))
    else $error("min not clipped");
  chk_max_clip: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn && floor_v <= ceil_v |=> eff_max <= $past(ceil_v))
    else $error("max not clipped");
  chk_fixed_eq: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn && c_min == c_max |=> eff_fixed)
    else $error("fixed mode missed");
  chk_target_auto: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_tgt == 8'h00 |=> eff_autonomous && eff_target == 8'h00)
    else $error("zero target not autonomous");
  chk_win_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    presetn |=> {window_exp, window_mant} == $past(src_hi))
    else $error("window fields misplaced");
  chk_unsup_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_tl && !cap_bias
      |=> prdata[31:24] == 8'h00)
    else $error("unsupported field read back");
  chk_pkg_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !cap_package && paddr == aph_pkg::OFF_PKG_LO |-> pslverr)
    else $error("package access not refused");
  chk_chg_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    chg_q && !(wr_fl && !pwdata[0]) |=> chg_q)
    else $error("change flag lost");
  chk_miss_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    miss_q && !(wr_fl && !pwdata[aph_pkg::MISS_B]) |=> miss_q)
    else $error("miss flag lost");
  chk_brief_miss: assert property (
    @(posedge pclk) disable iff (!presetn)
    !below_floor |=> !set_miss)
    else $error("brief excursion reported");
  chk_holdoff: assert property (
    @(posedge pclk) disable iff (!presetn)
    (set_chg || set_miss) |=> !(set_chg || set_miss) [*8])
    else $error("report within holdoff");
  chk_cur_log: assert property (
    @(posedge pclk) disable iff (!presetn)
    cur_st |=> cur_log_q)
    else $error("current log not set");
  chk_xd_log: assert property (
    @(posedge pclk) disable iff (!presetn)
    xd_st |=> xd_log_q)
    else $error("cross-domain log not set");
  chk_notify_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    notify_enable_register == 2'b00 |=> !notify)
    else $error("notify while disabled");
  chk_productive_cycle_count_inc: assert property (
    @(posedge pclk) disable iff (!presetn)
    actual_cycle_tick && productive |=> productive_cycle_count_q == $past(productive_cycle_count_q) + 64'h1)
    else $error("counter missed a cycle");
  chk_gate_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !auto_enabled && hit_tl |-> pslverr)
    else $error("hint access before enable");
endmodule : aph_regs
`default_nettype wire

// ---- sim/aph_regs_bench.sv ----
// Self-checking bench for the perf hint register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module aph_regs_bench;
  logic        pclk, presetn, psel, penable, pwrite;   // Clock, reset, APB
  logic [11:0] paddr;                                  // APB byte address
  logic [31:0] pwdata, prdata;                         // APB data
  logic [3:0]  pstrb;                                  // Byte enables
  logic        pready, pslverr;                        // APB answer
  logic        auto_en, cap_w, cap_b, cap_p;           // Enable and support
  logic [31:0] cap_reg;                                // Ceiling and floor
  logic [1:0]  note_en;                                // Notify enables
  logic        lvl_chg, below, cur_lim, xd_lim;        // Event levels
  logic        tick, prod;                             // Counter inputs
  logic [7:0]  e_min, e_max, e_tgt, e_bias;            // Effective hints
  logic        e_auto, e_fix, w_valid, notify;         // Effective modes
  logic [6:0]  w_mant;                                 // Window mantissa
  logic [2:0]  w_exp;                                  // Window exponent
  int          n_mismatch, total_checks, n_notify;     // Tallies
  // Short holdoff and sustain counts keep the run brief
  aph_regs #(.HOLDOFF_CYC(20), .SUSTAIN_CYC(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auto_enabled(auto_en), .capability_register(cap_reg),
    .cap_window(cap_w), .cap_bias(cap_b), .cap_package(cap_p),
    .notify_enable_register(note_en), .legacy_energy_bias_register(8'h5A),
    .level_changed(lvl_chg), .below_floor(below), .current_limit(cur_lim),
    .cross_limit(xd_lim), .actual_cycle_tick(tick), .productive(prod),
    .eff_min(e_min), .eff_max(e_max), .eff_target(e_tgt), .eff_bias(e_bias),
    .eff_autonomous(e_auto), .eff_fixed(e_fix), .window_valid(w_valid),
    .window_mant(w_mant), .window_exp(w_exp), .notify(notify));
  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Notify pulses counted mid-cycle, clear of edge races
  always @(negedge pclk) begin
    if (notify === 1'b1) n_notify++;
  end
  // One APB transfer; answer taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  // Registered outputs given time to follow, then looked at mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Hint registers refused while disabled; counter counts regardless
  task automatic t_gated();
    logic [31:0] a, b;
    logic        e;
    rd(aph_pkg::OFF_THR_LO, 32'h0, 1'b1);
    rd(12'h020, 32'h0, 1'b1);
    apb(1'b0, aph_pkg::OFF_PRODUCTIVE_CYCLE_COUNT_LO, 32'h0, 4'h0, a, e);
    `CHK(e, 1'b0)
    @(posedge pclk); tick <= 1'b1; prod <= 1'b1;
    repeat (10) @(posedge pclk);
    prod <= 1'b0;
    repeat (5) @(posedge pclk);
    tick <= 1'b0; prod <= 1'b1;
    repeat (5) @(posedge pclk);
    prod <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, aph_pkg::OFF_PRODUCTIVE_CYCLE_COUNT_LO, 32'h0, 4'h0, b, e);
    `CHK(b - a, 32'd10)
    rd(aph_pkg::OFF_PRODUCTIVE_CYCLE_COUNT_HI, 32'h0, 1'b0);
  endtask
  // Reset values, clipping, target, window and fixed mode
  task automatic t_hints();
    rd(aph_pkg::OFF_THR_LO, 32'h8000_F010, 1'b0);
    rd(aph_pkg::OFF_THR_HI, 32'h0, 1'b0);
    rd(aph_pkg::OFF_FLAGS, 32'h0, 1'b0);
    rd(aph_pkg::OFF_THERM, 32'h0, 1'b0);
    wr(aph_pkg::OFF_THR_HI, 32'h0000_0085, 4'hF);
    wr(aph_pkg::OFF_THR_LO, 32'h3320_FF05, 4'hF);
    rd(aph_pkg::OFF_THR_LO, 32'h3320_FF05, 1'b0);
    settle(4);
    `CHK({e_min, e_max}, 16'h10F0)
    `CHK({e_tgt, e_bias, e_auto}, 17'h0_4066)
    `CHK(w_valid, 1'b0)
    wr(aph_pkg::OFF_THR_LO, 32'h3300_4040, 4'hF);
    settle(4);
    `CHK({e_fix, e_auto, w_valid}, 3'b111)
    `CHK({w_exp, w_mant}, 10'h085)
    rd(aph_pkg::OFF_THR_HI, 32'h0000_0085, 1'b0);
    @(posedge pclk); cap_b <= 1'b0; cap_w <= 1'b0;
    settle(4);
    `CHK(e_bias, 8'h5A)
    rd(aph_pkg::OFF_THR_LO, 32'h0000_4040, 1'b0);
    rd(aph_pkg::OFF_THR_HI, 32'h0, 1'b0);
    @(posedge pclk); cap_b <= 1'b1; cap_w <= 1'b1;
  endtask
  // Package follow selects package hints; unsupported package refused
  task automatic t_pkg();
    wr(aph_pkg::OFF_PKG_LO, 32'h0000_6030, 4'hF);
    wr(aph_pkg::OFF_THR_HI, 32'h0000_0400, 4'hF);
    settle(4);
    `CHK({e_min, e_max, e_fix}, 17'h0_60C0)
    wr(aph_pkg::OFF_THR_HI, 32'h0, 4'hF);
    settle(4);
    `CHK({e_min, e_max}, 16'h4040)
    @(posedge pclk); cap_p <= 1'b0;
    rd(aph_pkg::OFF_PKG_LO, 32'h0, 1'b1);
    @(posedge pclk); cap_p <= 1'b1;
  endtask
  // Sticky change and miss flags, notify gating, brief and holdoff cases
  task automatic t_flags();
    @(posedge pclk); note_en <= 2'b10;
    repeat (25) @(posedge pclk);
    lvl_chg <= 1'b1;
    @(posedge pclk); lvl_chg <= 1'b0;
    settle(4);
    rd(aph_pkg::OFF_FLAGS, 32'h1, 1'b0);
    `CHK(n_notify, 0)
    wr(aph_pkg::OFF_FLAGS, 32'h0, 4'h1);
    rd(aph_pkg::OFF_FLAGS, 32'h0, 1'b0);
    repeat (25) @(posedge pclk);
    below <= 1'b1;
    repeat (2) @(posedge pclk);
    below <= 1'b0;
    settle(6);
    rd(aph_pkg::OFF_FLAGS, 32'h0, 1'b0);
    @(posedge pclk); below <= 1'b1;
    repeat (10) @(posedge pclk);
    below <= 1'b0;
    settle(4);
    rd(aph_pkg::OFF_FLAGS, 32'h4, 1'b0);
    `CHK(n_notify, 1)
    wr(aph_pkg::OFF_FLAGS, 32'h0, 4'h1);
    @(posedge pclk); lvl_chg <= 1'b1;
    @(posedge pclk); lvl_chg <= 1'b0;
    settle(4);
    rd(aph_pkg::OFF_FLAGS, 32'h0, 1'b0);
    // Holdoff over; change notify enabled alone this time
    repeat (25) @(posedge pclk);
    note_en <= 2'b01;
    lvl_chg <= 1'b1;
    @(posedge pclk);
    lvl_chg <= 1'b0;
    settle(4);
    `CHK(n_notify, 2)
    rd(aph_pkg::OFF_FLAGS, 32'h1, 1'b0);
    wr(aph_pkg::OFF_FLAGS, 32'h0, 4'h1);
  endtask
  // Live limit bits follow inputs, log bits stick until written zero
  task automatic t_therm();
    @(posedge pclk); cur_lim <= 1'b1; xd_lim <= 1'b1;
    settle(5);
    rd(aph_pkg::OFF_THERM, 32'h0000_F000, 1'b0);
    @(posedge pclk); cur_lim <= 1'b0; xd_lim <= 1'b0;
    settle(5);
    rd(aph_pkg::OFF_THERM, 32'h0000_A000, 1'b0);
    wr(aph_pkg::OFF_THERM, 32'h0, 4'h2);
    rd(aph_pkg::OFF_THERM, 32'h0, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 25);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    n_mismatch = 0; total_checks = 0; n_notify = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0;
    auto_en = 1'b0; cap_w = 1'b1; cap_b = 1'b1; cap_p = 1'b1;
    cap_reg = 32'h1000_00F0; note_en = 2'b00; lvl_chg = 1'b0;
    below = 1'b0; cur_lim = 1'b0; xd_lim = 1'b0; tick = 1'b0; prod = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_gated();
    @(posedge pclk); auto_en <= 1'b1;
    settle(3);
    `CHK(e_auto, 1'b1)
    t_hints();
    t_pkg();
    t_flags();
    t_therm();
    tally_and_finish();
  end
endmodule // aph_regs_bench
`undef CHK
`default_nettype wire
